// ---- design/cct_timer.sv ----
/*
 Capture/compare timer control block with an AXI4-Lite register slave.
 Assumes capture and external clock pins are asynchronous to aclk and
 that software accesses registers as full 16-bit quantities.
*/
module cct_timer (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Timer pins
   input  wire logic        capture_in_a,
   input  wire logic        capture_in_b,
   input  wire logic        external_tick_in,
   output logic             compare_out_a,
   output logic             compare_out_a_oe,
   output logic             compare_out_b,
   output logic             compare_out_b_oe,
   output logic             timer_irq
);
   // Whole state of the block
   typedef struct packed {
      cct_pkg::cct_regs_type regs;
      logic [15:0] count;
      logic [15:0] cap_a;
      logic [15:0] cap_b;
      logic [7:0]  presc;
      logic [2:0]  sync1;
      logic [2:0]  sync2;
      logic [2:0]  prev;
      logic        pulse_measure_mode_first;
      logic        aw_hold;
      logic        w_hold;
      cct_pkg::cct_wreq_type wreq;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        pin_a;
      logic        pin_b;
      logic        irq;
   } cct_state_type;

   cct_state_type s_q;
   cct_state_type s_d;

   // Read decode of the register map
   function automatic logic [31:0] cct_read(input cct_state_type s,
                                           input logic [4:0] off,
                                           output logic ok);
      logic [15:0] v;
      v  = 16'h0000;
      ok = 1'b1;
      unique case (off)
         5'h00:                v = s.cap_a;
         5'h04:                v = s.cap_b;
         cct_pkg::OFF_CMP_A:   v = s.regs.cmp_a;
         cct_pkg::OFF_CMP_B:   v = s.regs.cmp_b;
         cct_pkg::OFF_COUNT:   v = s.count;
         cct_pkg::OFF_MODE:    v = s.regs.mode;
         cct_pkg::OFF_IRQPS:   v = s.regs.irqps;
         cct_pkg::OFF_STATUS:  v = s.regs.flags;
         default:              ok = 1'b0;
      endcase
      return {16'h0000, v};
   endfunction

   // Timer, bus slave and pin logic
   always_comb begin
      logic        tick;
      logic        ext_edge;
      logic        cap_a_ev;
      logic        cap_b_ev;
      logic        match_a;
      logic        match_b;
      logic        single_pulse_mode;
      logic        pwm;
      logic        cnt_wr;
      logic        do_wr;
      logic        ok;
      logic [15:0] wv;
      logic [15:0] set_f;
      logic [15:0] m;
      s_d      = s_q;
      m        = s_q.regs.mode;
      set_f    = 16'h0000;
      cnt_wr   = 1'b0;
      ok       = 1'b0;
      wv       = s_q.wreq.data[15:0];
      // Pin synchronisers: second stage is the only reader of the first
      s_d.sync1 = {external_tick_in, capture_in_b, capture_in_a};
      s_d.sync2 = s_q.sync1;
      s_d.prev  = s_q.sync2;
      ext_edge = m[cct_pkg::B_EXT_CLOCK_EDGE_SEL] ?
                 (s_q.sync2[2] & ~s_q.prev[2]) :
                 (~s_q.sync2[2] & s_q.prev[2]);
      cap_a_ev = m[cct_pkg::B_EDGA] ?
                 (s_q.sync2[0] & ~s_q.prev[0]) :
                 (~s_q.sync2[0] & s_q.prev[0]);
      cap_b_ev = m[cct_pkg::B_EDGB] ?
                 (s_q.sync2[1] & ~s_q.prev[1]) :
                 (~s_q.sync2[1] & s_q.prev[1]);
      // Mode priority when both pulse modes are set
      single_pulse_mode = m[cct_pkg::B_OPM] & (~m[cct_pkg::B_PWM] | m[cct_pkg::B_FRCA]);
      pwm = m[cct_pkg::B_PWM] & ~single_pulse_mode;
      // Prescaler: one tick every N+1 bus clocks
      tick = 1'b0;
      if (m[cct_pkg::B_EN]) begin
         if (s_q.presc == s_q.regs.irqps[7:0]) begin
            s_d.presc = 8'h00;
            tick      = ~m[cct_pkg::B_EXSEL];
         end else begin
            s_d.presc = s_q.presc + 8'h01;
         end
         if (m[cct_pkg::B_EXSEL])
            tick = ext_edge;
      end else begin
         s_d.presc = 8'h00;
      end
      match_a = tick & (s_q.count == s_q.regs.cmp_a);
      match_b = tick & (s_q.count == s_q.regs.cmp_b);
      // Counter advance and wrap
      if (tick) begin
         s_d.count = s_q.count + 16'h0001;
         if (s_q.count == cct_pkg::CNT_MAX)
            set_f[cct_pkg::B_OVF] = 1'b1;
      end
      if (pwm && match_b)
         s_d.count = cct_pkg::CNT_RST;
      // Captures and the pulse measure restart
      if (cap_a_ev) begin
         s_d.cap_a = s_q.count;
         if (m[cct_pkg::B_PULSE_MEASURE_MODE]) begin
            s_d.count      = cct_pkg::CNT_ZERO;
            s_d.pulse_measure_mode_first = 1'b0;
            set_f[cct_pkg::B_CAPA] = ~s_q.pulse_measure_mode_first;
         end else begin
            set_f[cct_pkg::B_CAPA] = 1'b1;
         end
         if (single_pulse_mode) begin
            s_d.count = cct_pkg::CNT_RST;
            s_d.pin_a = m[cct_pkg::B_LVLB];
         end
      end
      if (!m[cct_pkg::B_PULSE_MEASURE_MODE])
         s_d.pulse_measure_mode_first = 1'b1;
      if (cap_b_ev) begin
         s_d.cap_b = s_q.count;
         set_f[cct_pkg::B_CAPB] = 1'b1;
      end
      // Compare outcomes on the pins and flags
      set_f[cct_pkg::B_CMPB] = match_b;
      set_f[cct_pkg::B_CMPA] = match_a & ~pwm & ~single_pulse_mode;
      if (match_a)
         s_d.pin_a = m[cct_pkg::B_LVLA];
      if (pwm && match_b)
         s_d.pin_a = m[cct_pkg::B_LVLB];
      if (match_b)
         s_d.pin_b = m[cct_pkg::B_LVLB];
      // AXI write: address and data taken in either order
      if (s_q.aw_hold == 1'b0 && s_axi_awvalid) begin
         s_d.aw_hold   = 1'b1;
         s_d.wreq.addr = s_axi_awaddr;
      end
      if (s_q.w_hold == 1'b0 && s_axi_wvalid) begin
         s_d.w_hold    = 1'b1;
         s_d.wreq.data = s_axi_wdata;
         s_d.wreq.strb = s_axi_wstrb;
      end
      do_wr = s_q.aw_hold & s_q.w_hold & ~s_q.bvalid;
      if (do_wr) begin
         s_d.aw_hold = 1'b0;
         s_d.w_hold  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = cct_pkg::RESP_OKAY;
         // Half-word writes need both low lanes
         if (s_q.wreq.strb[1:0] != 2'b11) begin
         end else begin
            unique case (s_q.wreq.addr[4:0])
               cct_pkg::OFF_CMP_A: s_d.regs.cmp_a = wv;
               cct_pkg::OFF_CMP_B: s_d.regs.cmp_b = wv;
               cct_pkg::OFF_COUNT: cnt_wr = 1'b1;
               cct_pkg::OFF_MODE: begin
                  s_d.regs.mode = wv & cct_pkg::MODE_WMASK;
                  if (wv[cct_pkg::B_FRCA])
                     s_d.pin_a = wv[cct_pkg::B_LVLA];
                  if (wv[cct_pkg::B_FRCB])
                     s_d.pin_b = wv[cct_pkg::B_LVLB];
               end
               cct_pkg::OFF_IRQPS:
                  s_d.regs.irqps = wv & cct_pkg::IRQ_WMASK;
               cct_pkg::OFF_STATUS:
                  // Zero clears a flag; new events below still win
                  s_d.regs.flags = s_q.regs.flags & wv;
               5'h00, 5'h04: ;
               default: s_d.bresp = cct_pkg::RESP_SLVERR;
            endcase
         end
         if (s_q.wreq.addr[31:5] != 27'h0)
            s_d.bresp = cct_pkg::RESP_SLVERR;
      end
      if (cnt_wr) begin
         s_d.count = cct_pkg::CNT_RST;
         s_d.presc = 8'h00;
      end
      s_d.regs.flags = (s_d.regs.flags | set_f) & cct_pkg::FLAG_MASK;
      if (s_q.bvalid && s_axi_bready)
         s_d.bvalid = 1'b0;
      // AXI read: one outstanding, answer next cycle
      if (s_axi_arvalid && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         s_d.rdata  = cct_read(s_q, s_axi_araddr[4:0], ok);
         if (!ok || s_axi_araddr[31:5] != 27'h0) begin
            s_d.rresp = cct_pkg::RESP_SLVERR;
            s_d.rdata = 32'h0000_0000;
         end else begin
            s_d.rresp = cct_pkg::RESP_OKAY;
         end
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      // Interrupt request from flags and enables
      s_d.irq = |(s_d.regs.flags & s_d.regs.irqps
                  & cct_pkg::FLAG_MASK);
   end

   // Registered state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q            <= '0;
         s_q.regs.cmp_a <= cct_pkg::CMP_RST;
         s_q.regs.cmp_b <= cct_pkg::CMP_RST;
         s_q.count      <= cct_pkg::CNT_RST;
         s_q.regs.mode  <= cct_pkg::CTL_RST;
         // Sync chains clear to the idle low pin level: no false edge
         s_q.pulse_measure_mode_first <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops
   assign s_axi_awready    = ~s_q.aw_hold;
   assign s_axi_wready     = ~s_q.w_hold;
   assign s_axi_bvalid     = s_q.bvalid;
   assign s_axi_bresp      = s_q.bresp;
   assign s_axi_arready    = ~s_q.rvalid;
   assign s_axi_rvalid     = s_q.rvalid;
   assign s_axi_rdata      = s_q.rdata;
   assign s_axi_rresp      = s_q.rresp;
   assign compare_out_a    = s_q.pin_a;
   assign compare_out_b    = s_q.pin_b;
   assign compare_out_a_oe = s_q.regs.mode[cct_pkg::B_PENA];
   assign compare_out_b_oe = s_q.regs.mode[cct_pkg::B_PENB];
   assign timer_irq        = s_q.irq;
endmodule

// ---- design/cct_pkg.sv ----
/*
 Package of the capture/compare timer control block: register offsets,
 field positions, reset values and bus carrier types.
 Assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
*/
package cct_pkg;
   // Register byte offsets
   localparam logic [4:0] OFF_CMP_A   = 5'h08;
   localparam logic [4:0] OFF_CMP_B   = 5'h0C;
   localparam logic [4:0] OFF_COUNT   = 5'h10;
   localparam logic [4:0] OFF_MODE    = 5'h14;
   localparam logic [4:0] OFF_IRQPS   = 5'h18;
   localparam logic [4:0] OFF_STATUS  = 5'h1C;
   // Reset values, counter top and pulse measure restart value
   localparam logic [15:0] CMP_RST    = 16'h8000;
   localparam logic [15:0] CNT_RST    = 16'hFFFC;
   localparam logic [15:0] CTL_RST    = 16'h0000;
   localparam logic [15:0] CNT_MAX    = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO   = 16'h0000;
   // Mode control bit positions
   localparam int B_EN    = 15;
   localparam int B_PULSE_MEASURE_MODE  = 14;
   localparam int B_FRCB  = 11;
   localparam int B_FRCA  = 10;
   localparam int B_LVLB  = 9;
   localparam int B_LVLA  = 8;
   localparam int B_PENB  = 7;
   localparam int B_PENA  = 6;
   localparam int B_OPM   = 5;
   localparam int B_PWM   = 4;
   localparam int B_EDGB  = 3;
   localparam int B_EDGA  = 2;
   localparam int B_EXT_CLOCK_EDGE_SEL = 1;
   localparam int B_EXSEL = 0;
   // Interrupt enable / status bit positions
   localparam int B_CAPA  = 15;
   localparam int B_CMPA  = 14;
   localparam int B_OVF   = 13;
   localparam int B_CAPB  = 12;
   localparam int B_CMPB  = 11;
   localparam logic [15:0] MODE_WMASK = 16'hCFFF;
   localparam logic [15:0] IRQ_WMASK  = 16'hF8FF;
   localparam logic [15:0] FLAG_MASK  = 16'hF800;
   // AXI4-Lite responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Write request carrier
   typedef struct packed {
      logic [31:0] addr;
      logic [31:0] data;
      logic [3:0]  strb;
   } cct_wreq_type;

   // Register set
   typedef struct packed {
      logic [15:0] cmp_a;
      logic [15:0] cmp_b;
      logic [15:0] mode;
      logic [15:0] irqps;
      logic [15:0] flags;
   } cct_regs_type;
endpackage

// ---- testbench/cct_pins_model.sv ----
/*
 Pin-side partner: capture inputs and external tick source.
 Assumes pins idle low and pulses far slower than aclk.
*/
module cct_pins_model (
   // Clock
   input  wire logic aclk,
   // Pins toward the timer
   output logic      capture_in_a,
   output logic      capture_in_b,
   output logic      external_tick_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle low between pulses
   initial {capture_in_a, capture_in_b, external_tick_in} = 3'h0;
   // Pulses of 4 clocks high, 4 low; pin 0 tick, 1 capture A, 2 B
   task automatic pulse(input int p, input int n);
      for (int i = 0; i < 2 * n; i++) begin
         @(posedge aclk);
         case (p)
            0: external_tick_in <= ~external_tick_in;
            1: capture_in_a <= ~capture_in_a;
            default: capture_in_b <= ~capture_in_b;
         endcase
         repeat (3) @(posedge aclk);
      end
   endtask
endmodule

// ---- testbench/cct_timer_assertions.sv ----
/*
 Handshake checker for the timer register bus.
 Assumes it is bound to cct_timer, one clock domain.
*/
module cct_timer_assertions (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Write channels
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // Read channels
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Handshake steps
   sequence s_aw_taken;
      s_axi_awvalid && s_axi_awready;
   endsequence
   sequence s_w_taken;
      s_axi_wvalid && s_axi_wready;
   endsequence
   a_aw_held: assert property (s_aw_taken |=> !s_axi_awready)
      else $error("awready stayed high");
   a_w_held: assert property (s_w_taken |=> !s_axi_wready)
      else $error("wready stayed high");
   a_write_answer: assert property (
      s_aw_taken ##0 s_w_taken |-> ##2 s_axi_bvalid)
      else $error("write response late");
   a_bresp_stable: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_rdata_stable: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   a_upper_zero: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
endmodule
bind cct_timer cct_timer_assertions chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready);

// ---- testbench/cct_timer_test.sv ----
/*
 Self-checking bench of the timer control block.
 Assumes the pin model and the bound bus checker.
*/
module cct_timer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, timer_irq;
   logic        capture_in_a, capture_in_b, external_tick_in, compare_out_a;
   logic        compare_out_a_oe, compare_out_b, compare_out_b_oe;
   int          mismatches, total_checks;
   logic [31:0] d;
   logic [1:0]  r;
   cct_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_in_a,
      .capture_in_b, .external_tick_in, .compare_out_a, .compare_out_a_oe,
      .compare_out_b, .compare_out_b_oe, .timer_irq);
   cct_pins_model pins (.aclk, .capture_in_a, .capture_in_b,
      .external_tick_in);
   // Compare and closing report
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results;
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic tmo(input logic ok);
      if (!ok) begin
         mismatches++;
         results();
      end
   endtask
   // Bus write: address and data together, bready held high
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      int   n = 0;
      logic ta, tw, tb = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= {16'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!tb && n < 64) begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         n++;
      end
      s_axi_bready <= 1'b0;
      tmo(tb);
   endtask
   // Bus read, rready held high until data arrives
   task automatic rd(input logic [7:0] a);
      int   n = 0;
      logic ta, tb = 1'b0;
      @(posedge aclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!tb && n < 64) begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tb = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'b0;
         n++;
      end
      s_axi_rready <= 1'b0;
      tmo(tb);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [15:0] m,
                       input logic [15:0] e);
      rd(a);
      chk(d & {16'hFFFF, m}, {16'h0, e});
   endtask
   task automatic pins_chk(input logic [31:0] e);
      repeat (2) @(posedge aclk);
      chk({28'h0, compare_out_a, compare_out_a_oe, compare_out_b,
           compare_out_b_oe}, e);
   endtask
   // Reset values and an unmapped offset
   task automatic t_reset;
      rchk(8'h08, 16'hFFFF, 16'h8000);
      rchk(8'h0C, 16'hFFFF, 16'h8000);
      rchk(8'h10, 16'hFFFF, 16'hFFFC);
      rchk(8'h14, 16'hFFFF, 16'h0000);
      rd(8'h20);
      chk({30'h0, r}, {30'h0, cct_pkg::RESP_SLVERR});
   endtask
   // Counter write restarts, stopped counter holds
   task automatic t_count;
      wr(8'h08, 16'h1234);
      rchk(8'h08, 16'hFFFF, 16'h1234);
      wr(8'h10, 16'h1234);
      repeat (10) @(posedge aclk);
      rchk(8'h10, 16'hFFFF, 16'hFFFC);
   endtask
   // Prescale by two, rollover flag and its interrupt
   task automatic t_overflow;
      wr(8'h18, 16'h2001);
      wr(8'h10, 16'h0000);
      wr(8'h14, 16'h8000);
      repeat (40) @(posedge aclk);
      rd(8'h10);
      chk({31'h0, d[15:0] inside {[16'h000E:16'h0016]}}, 32'h1);
      rchk(8'h1C, 16'h2000, 16'h2000);
      chk({31'h0, timer_irq}, 32'h1);
      wr(8'h1C, 16'h0000);
      wr(8'h14, 16'h0000);
      repeat (3) @(posedge aclk);
      chk({31'h0, timer_irq}, 32'h0);
   endtask
   // Forced levels; a clear force bit leaves the pin alone
   task automatic t_force;
      wr(8'h14, 16'h0540);
      pins_chk(32'hC);
      wr(8'h14, 16'h0A80);
      pins_chk(32'hB);
      wr(8'h14, 16'h0080);
      pins_chk(32'hB);
   endtask
   // Compare matches drive both pins and set both flags
   task automatic t_match;
      wr(8'h14, 16'h0CC0);
      wr(8'h08, 16'h0002);
      wr(8'h0C, 16'h0004);
      wr(8'h18, 16'h0000);
      wr(8'h1C, 16'h0000);
      wr(8'h10, 16'h0000);
      pins_chk(32'h5);
      wr(8'h14, 16'h83C0);
      repeat (30) @(posedge aclk);
      pins_chk(32'hF);
      rchk(8'h1C, 16'h4800, 16'h4800);
      wr(8'h14, 16'h0000);
   endtask
   // External ticks on rising, then on falling edges
   task automatic t_ext;
      wr(8'h10, 16'h0000);
      wr(8'h14, 16'h8003);
      pins.pulse(0, 5);
      rchk(8'h10, 16'hFFFF, 16'h0001);
      wr(8'h10, 16'h0000);
      wr(8'h14, 16'h8001);
      pins.pulse(0, 3);
      rchk(8'h10, 16'hFFFF, 16'hFFFF);
   endtask
   // Capture A on rising, B on falling edge, A interrupt enabled
   task automatic t_capture;
      wr(8'h14, 16'h0004);
      wr(8'h1C, 16'h0000);
      wr(8'h18, 16'h8000);
      pins.pulse(1, 1);
      pins.pulse(2, 1);
      rchk(8'h1C, 16'h9000, 16'h9000);
      chk({31'h0, timer_irq}, 32'h1);
   endtask
   // Single pulse: capture A rise drives level B on pin A until match A
   task automatic t_pulse;
      wr(8'h14, 16'h0440);
      wr(8'h08, 16'h0100);
      wr(8'h14, 16'h8264);
      pins.pulse(1, 1);
      pins_chk(32'hE);
      repeat (300) @(posedge aclk);
      pins_chk(32'h6);
      wr(8'h14, 16'h0000);
   endtask
   // Clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // Reset, then scenarios in turn
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
      s_axi_wstrb = 4'hF;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_count();
      t_overflow();
      t_force();
      t_match();
      t_ext();
      t_capture();
      t_pulse();
      results();
   end
endmodule
